// ==== verilog/tpo_unit.v ====
// Triggered 8-bit parallel output unit with buffered nibbles and per-pin mode
`timescale 1ns/1ps
`default_nettype none
`include "tpo_map.vh"

// Functional notes
// - Two 4-bit buffer halves hold next pattern
// - Dual mode: writes touch only addressed nibble
// - Single mode: either address loads both halves
// - Buffer read returns high and low combined
// - Port-mode bits read back as zero
// - Reset clears buffers; byte-wide buffer access
// - Trigger copies buffers to latch in hardware
// - Output latch hidden from software
// - Buffered pins ignore port latch writes
// - Pin mode bit: 0 port, 1 buffered
// - Pin mode: bit or byte writes, reset zero
// - Triggers: external edge, timer4, timer5 events
// - Control: enable, edge, mode, external use bits
// - Trigger routing per mode and external use
// - Port-mode pins and disabled unit drive zero
module tpo_unit
(
   input wire i_clock,
   input wire i_rst,
   input wire [31:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire i_bit_op,
   input wire [2:0] i_bit_sel,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   input wire [7:0] i_port_wdata,
   input wire i_port_wr,
   input wire i_external_trigger_input,
   input wire i_timer4_event,
   input wire i_timer5_event,
   output reg [7:0] o_buffered_output_pin
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [7:0] pin_mode_r;
   reg [3:0] buf_low_r;
   reg [3:0] buf_high_r;
   reg [7:0] control_r;
   reg [7:0] latch_r;
   reg [7:0] latch_nxt;
   reg [7:0] pin_mode_nxt;
   reg [7:0] control_nxt;
   wire ext_pulse;
   wire sel_pin_mode;
   wire sel_low;
   wire sel_high;
   wire sel_control;
   wire enable;
   wire single_mode;
   wire ext_use;
   reg trig_high;
   reg trig_low;

   assign sel_pin_mode = (i_addr == `TPO_ADDR_PIN_MODE);
   assign sel_low = (i_addr == `TPO_ADDR_BUF_LOW);
   assign sel_high = (i_addr == `TPO_ADDR_BUF_HIGH);
   assign sel_control = (i_addr == `TPO_ADDR_CONTROL);
   assign enable = control_r[`TPO_CTL_ENABLE];
   assign single_mode = control_r[`TPO_CTL_MODE];
   assign ext_use = control_r[`TPO_CTL_EXT];

   tpo_edge_detect i_tpo_edge_detect
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_external_trigger_input),
      .i_rising(control_r[`TPO_CTL_EDGE]),
      .o_pulse(ext_pulse)
   );

   // ----------------------------------------------------------------
   // Trigger routing
   // ----------------------------------------------------------------
   always @*
   begin
      if (single_mode)
      begin
         trig_high = ext_use ? ext_pulse : i_timer4_event;
         trig_low = trig_high;
      end
      else if (ext_use)
      begin
         trig_high = i_timer4_event;
         trig_low = ext_pulse;
      end
      else
      begin
         trig_high = i_timer5_event;
         trig_low = i_timer4_event;
      end
   end

   // ----------------------------------------------------------------
   // Bit-or-byte writes to pin mode and control
   // ----------------------------------------------------------------
   always @*
   begin
      pin_mode_nxt = pin_mode_r;
      control_nxt = control_r;
      if (i_wr && sel_pin_mode)
      begin
         if (i_bit_op)
            pin_mode_nxt[i_bit_sel] = i_wdata[0];
         else
            pin_mode_nxt = i_wdata;
      end
      if (i_wr && sel_control)
      begin
         if (i_bit_op)
            control_nxt[i_bit_sel] = i_wdata[0];
         else
            control_nxt = i_wdata;
         control_nxt = control_nxt & `TPO_CTL_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Output latch: port writes reach only port-mode bits, triggers
   // load whole nibbles, port-mode bits included. Software cannot read this latch.
   // ----------------------------------------------------------------
   always @*
   begin
      latch_nxt = latch_r;
      if (i_port_wr)
         latch_nxt = (latch_r & pin_mode_r) | (i_port_wdata & ~pin_mode_r);
      if (enable && trig_high)
         latch_nxt[7:4] = buf_high_r;
      if (enable && trig_low)
         latch_nxt[3:0] = buf_low_r;
   end

   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         pin_mode_r <= `TPO_RST_PIN_MODE;
         control_r <= `TPO_RST_CONTROL;
         buf_low_r <= `TPO_RST_BUF;
         buf_high_r <= `TPO_RST_BUF;
         latch_r <= 8'h00;
         o_rdata <= 8'h00;
         o_buffered_output_pin <= 8'h00;
      end
      else
      begin
         pin_mode_r <= pin_mode_nxt;
         control_r <= control_nxt;
         latch_r <= latch_nxt;
         // Buffers take byte writes only; bit operations are ignored
         if (i_wr && !i_bit_op && (sel_low || sel_high))
         begin
            if (single_mode)
            begin
               buf_high_r <= i_wdata[7:4];
               buf_low_r <= i_wdata[3:0];
            end
            else if (sel_low)
               buf_low_r <= i_wdata[3:0];
            else
               buf_high_r <= i_wdata[7:4];
         end
         // Read data registered; the latch itself is never on this path
         if (i_rd && (sel_low || sel_high))
            o_rdata <= {buf_high_r, buf_low_r} & pin_mode_r;
         else if (i_rd && sel_pin_mode)
            o_rdata <= pin_mode_r;
         else if (i_rd && sel_control)
            o_rdata <= control_r;
         else
            o_rdata <= 8'h00;
         // Disabled unit drives all zero whatever the pin modes
         o_buffered_output_pin <= enable ? (latch_r & pin_mode_r) : 8'h00;
      end
   end

endmodule // tpo_unit

`default_nettype wire

// ==== verilog/tpo_map.vh ====
// Register offsets, field positions and reset values of the triggered output unit
`ifndef TPO_MAP_VH
`define TPO_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TPO_ADDR_PIN_MODE 32'hFFFFF3A4
`define TPO_ADDR_BUF_LOW 32'hFFFFF3A0
`define TPO_ADDR_BUF_HIGH 32'hFFFFF3A2
`define TPO_ADDR_CONTROL 32'hFFFFF3A5

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TPO_CTL_ENABLE 7
`define TPO_CTL_EDGE 6
`define TPO_CTL_MODE 5
`define TPO_CTL_EXT 4
`define TPO_CTL_MASK 8'hF0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPO_RST_PIN_MODE 8'h00
`define TPO_RST_BUF 4'h0
`define TPO_RST_CONTROL 8'h00

`endif

// ==== verilog/tpo_edge_detect.v ====
// Synchroniser and selectable edge detector for the external trigger input
`timescale 1ns/1ps
`default_nettype none

module tpo_edge_detect
(
   input wire i_clock,
   input wire i_rst,
   input wire i_level,
   input wire i_rising,
   output reg o_pulse
);

   reg sync1_r;
   reg sync2_r;
   reg prev_r;

   // Two flops before any logic reads the pin
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
         o_pulse <= 1'b0;
      end
      else
      begin
         sync1_r <= i_level;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         o_pulse <= i_rising ? (sync2_r & ~prev_r) : (~sync2_r & prev_r);
      end
   end

endmodule // tpo_edge_detect

`default_nettype wire

// ==== sim/tpo_stage_model.sv ====
// Stage driver model: echoes step requests onto the trigger pin
`timescale 1ns/1ps
`default_nettype none
module tpo_stage_model
(
   input wire logic i_clock,
   input wire logic i_step,
   input wire logic [7:0] i_coils,
   output var logic o_edge,
   output var logic [7:0] o_seen
);
   initial o_edge = 1'b0;
   // Edge lands off the clock, as a real pin would
   always @(i_step) o_edge <= #3 i_step;
   always @(posedge i_clock) o_seen <= i_coils;
endmodule // tpo_stage_model
`default_nettype wire

// ==== sim/tpo_unit_sva.sv ====
// Port checker for the triggered output unit
`timescale 1ns/1ps
`default_nettype none
`include "tpo_map.vh"
module tpo_unit_sva
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [31:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_bit_op,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] i_port_wdata,
   input wire logic i_port_wr,
   input wire logic i_external_trigger_input,
   input wire logic i_timer4_event,
   input wire logic i_timer5_event,
   input wire logic [7:0] o_buffered_output_pin
);
   logic [7:0] pm_r;
   logic en_r;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ----
   // Shadows of pin mode and enable, bit writes included
   // ----
   always @(posedge i_clock)
      if (i_rst)
         {pm_r, en_r} <= 9'h000;
      else if (i_wr && i_addr == `TPO_ADDR_CONTROL && i_bit_op)
         en_r <= (i_bit_sel == 3'h7) ? i_wdata[0] : en_r;
      else if (i_wr && i_addr == `TPO_ADDR_CONTROL)
         en_r <= i_wdata[7];
      else if (i_wr && i_addr == `TPO_ADDR_PIN_MODE && i_bit_op)
         pm_r[i_bit_sel] <= i_wdata[0];
      else if (i_wr && i_addr == `TPO_ADDR_PIN_MODE)
         pm_r <= i_wdata;
   // ----
   // Properties
   // ----
   pin_reset_a: assert property ($fell(i_rst) |-> o_buffered_output_pin == 8'h00)
      else $error("pins after reset");
   rd_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("idle read data");
   ctl_rd_a: assert property (i_rd && i_addr == `TPO_ADDR_CONTROL |=> o_rdata[3:0] == 4'h0)
      else $error("control low bits");
   mode_rd_a: assert property (i_rd && i_addr == `TPO_ADDR_PIN_MODE |=> o_rdata == $past(pm_r))
      else $error("pin mode read");
   buf_rd_a: assert property ((i_rd && (i_addr == `TPO_ADDR_BUF_LOW ||
      i_addr == `TPO_ADDR_BUF_HIGH)) |=> (o_rdata & ~$past(pm_r)) == 8'h00)
      else $error("buffer read mask");
   port_mask_a: assert property (1 |=> (o_buffered_output_pin & ~$past(pm_r)) == 8'h00)
      else $error("port pin driven");
   disabled_zero_a: assert property (!en_r |=> o_buffered_output_pin == 8'h00)
      else $error("disabled pins");
   pin_hold_a: assert property ((!i_wr && !i_timer4_event && !i_timer5_event &&
      $stable(i_external_trigger_input))[*8] |=> $stable(o_buffered_output_pin))
      else $error("pins moved");
   c_t4: cover property (i_timer4_event && en_r);
   c_ext: cover property ($rose(i_external_trigger_input) && en_r);
   c_bit: cover property (i_wr && i_bit_op);
endmodule // tpo_unit_sva
bind tpo_unit tpo_unit_sva i_sva (.*);
`default_nettype wire

// ==== sim/tpo_unit_bench.sv ====
// Self-checking bench for the triggered output unit
`timescale 1ns/1ps
`default_nettype none
`include "tpo_map.vh"
`define CHK(n,e,g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("mismatch %0s exp %h got %h", n, e, g); end end
module tpo_unit_bench;
   localparam logic [31:0] PM = `TPO_ADDR_PIN_MODE;
   localparam logic [31:0] BL = `TPO_ADDR_BUF_LOW;
   localparam logic [31:0] BH = `TPO_ADDR_BUF_HIGH;
   localparam logic [31:0] CT = `TPO_ADDR_CONTROL;
   logic i_clock, i_rst, wr, rd, bo, pw, t4, t5, stp, ext;
   logic [2:0] bs;
   logic [31:0] ad;
   logic [7:0] wd, rdat, pins, seen, pd;
   int err_count, samples_checked, cyc;
   tpo_unit i_tpo_unit (.i_clock(i_clock), .i_rst(i_rst), .i_addr(ad), .i_wr(wr), .i_rd(rd),
      .i_bit_op(bo), .i_bit_sel(bs), .i_wdata(wd), .o_rdata(rdat), .i_port_wdata(pd),
      .i_port_wr(pw), .i_external_trigger_input(ext), .i_timer4_event(t4),
      .i_timer5_event(t5), .o_buffered_output_pin(pins));
   tpo_stage_model i_tpo_stage_model (.i_clock(i_clock), .i_step(stp), .i_coils(pins),
      .o_edge(ext), .o_seen(seen));
   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic go(input logic [31:0] a, input logic [7:0] d, input logic w = 1,
      input logic b = 0, input logic [2:0] s = 0);
      @(posedge i_clock);
      #1 {wr, rd, bo, bs, ad, wd} = {w, !w, b, s, a, d};
      @(posedge i_clock);
      #1 {wr, rd} = 2'b00;
   endtask
   task automatic rdc(input logic [31:0] a, input logic [7:0] e);
      go(a, 8'h00, 1'b0);
      `CHK("rdata", e, rdat)
   endtask
   // Pulse timers or toggle the stage step, then look at the pins
   task automatic fire(input logic [2:0] t, input int w, input logic [7:0] e);
      @(posedge i_clock);
      #1 {stp, t5, t4} = {stp ^ t[2], t[1:0]};
      @(posedge i_clock);
      #1 {t5, t4} = 2'b00;
      repeat (w) @(posedge i_clock);
      #1 `CHK("pins", e, pins)
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge i_clock)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_count++;
         stop_test;
      end
   end
   initial
   begin
      {i_rst, wr, rd, bo, pw, t4, t5, stp, bs, ad, wd, pd} = {1'b1, 58'h0};
      repeat (3) @(posedge i_clock);
      #1 i_rst = 1'b0;
      rdc(PM, 8'h00);
      rdc(CT, 8'h00);
      go(PM, 8'hFF);
      go(BL, 8'h5A);
      go(BH, 8'h3C);
      rdc(BL, 8'h3A);
      go(PM, 8'h00, 1'b1, 1'b1, 3'h1);
      go(BL, 8'h01, 1'b1, 1'b1, 3'h2);
      rdc(BH, 8'h38);
      rdc(PM, 8'hFD);
      fire(3'b001, 2, 8'h00);
      go(CT, 8'hAF);
      rdc(CT, 8'hA0);
      go(BL, 8'h96);
      fire(3'b001, 2, 8'h94);
      @(posedge i_clock);
      #1 {pw, pd} = {1'b1, 8'hFF};
      @(posedge i_clock);
      #1 pw = 1'b0;
      go(BH, 8'h11);
      fire(3'b010, 2, 8'h94);
      go(CT, 8'hF0);
      fire(3'b100, 9, 8'h11);
      `CHK("stage", 8'h11, seen)
      go(CT, 8'h90);
      go(BH, 8'h70);
      go(BL, 8'h02);
      fire(3'b001, 2, 8'h71);
      fire(3'b100, 9, 8'h70);
      go(CT, 8'h80);
      go(BH, 8'hE0);
      go(BL, 8'h0B);
      fire(3'b010, 2, 8'hE0);
      fire(3'b001, 2, 8'hE9);
      go(CT, 8'h00);
      fire(3'b001, 2, 8'h00);
      rdc(32'h0, 8'h00);
      go(CT, 8'h01, 1'b1, 1'b1, 3'h7);
      rdc(CT, 8'h80);
      stop_test;
   end
endmodule // tpo_unit_bench
`default_nettype wire
